// file: hw/dew_pkg.sv
package dew_pkg;

  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  // register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR_LO = 8'h04;
  localparam logic [7:0] OFS_ADDR_HI = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_PTR1_HI = 8'h18;
  localparam logic [7:0] OFS_PTR2_HI = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // control register fields
  localparam int CTRL_MODE_BIT = 4;
  localparam int CTRL_WRITE_ENABLE_FLAG_BIT = 3;
  localparam int CTRL_WR_BIT = 2;

  // interrupt flag / enable fields
  localparam int FLAG_NVM_BIT = 0;
  localparam int FLAG_MF_BIT = 1;
  localparam int EN_NVM_BIT = 0;
  localparam int EN_MF_BIT = 1;
  localparam int EN_GLOBAL_BIT = 2;

  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SAT_BIT = 1;
  localparam int STAT_FAULT_BIT = 2;

  // array geometry: 6 page bits, 4 byte-in-page bits
  localparam int PAGE_BYTES = 16;
  localparam int LOW_W = 4;
  localparam int PAGE_W = 6;
  localparam int NVM_AW = LOW_W + PAGE_W;
  localparam int ADDR_HI_W = NVM_AW - 8;
  localparam logic [3:0] LOW_MAX = 4'hF;

  // sector that holds the control register
  localparam logic [7:0] SECTOR_CTRL = 8'h01;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: hw/dew_write_ctrl.sv
// Behaviour
// - mode bit zero: single byte written at address registers with data register
// - start counts only in the write right after the enable was set
// - start while enable is clear does nothing
// - array timer ends cycle; start bit self-clears for polling
// - byte mode erases the target byte before programming
// - mode bit one: page write of up to 16 bytes, same start sequence
// - page buffer cleared at reset and on enable falling, not rising
// - upper 6 address bits pick page, lower 4 the byte; upper never counts
// - page mode data write loads buffer slot then bumps low nibble
// - low nibble sticks at 0FH; later data writes not buffered
// - enable cleared by hardware once the write completes
// - enable cleared at power-on
// - pointer high bytes reset to 0; control reg reachable only via sector 1
// - cycle end sets memory flag and multi-function flag
// - vector jump needs global, memory, multi-function enables and free stack
// - service clears multi-function flag and global enable; software the other
// - no idle or sleep during a cycle; doing so makes it fail
// - control bits: mode 4, enable 3, start 2
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module dew_write_ctrl
  import dew_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dew_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dew_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dew_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dew_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic nvm_start,
  output logic nvm_preerase,
  output logic nvm_page,
  output logic [dew_pkg::NVM_AW-1:0] nvm_addr,
  output logic [dew_pkg::PAGE_BYTES*8-1:0] nvm_data,
  output logic [dew_pkg::PAGE_BYTES-1:0] nvm_mask,
  output logic nvm_abort,
  input wire logic nvm_done,
  input wire logic stack_full,
  input wire logic irq_service,
  input wire logic sleep_req,
  output logic irq_vector
);
  import dew_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane;
    logic mode;
    logic write_enable_flag;
    logic wr;
    logic arm;
    logic busy;
    logic [7:0] addr_lo;
    logic [ADDR_HI_W-1:0] addr_hi;
    logic [7:0] data;
    logic sat;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0] pmask;
    logic nvm_flag;
    logic mf_flag;
    logic en_nvm;
    logic en_mf;
    logic gie;
    logic fault;
    logic [7:0] ptr1h;
    logic [7:0] ptr2h;
    logic start;
    logic preerase;
    logic page;
    logic abort_p;
    logic vector;
    logic [NVM_AW-1:0] naddr;
    logic [PAGE_BYTES-1:0][7:0] ndata;
    logic [PAGE_BYTES-1:0] nmask;
  } dew_state_type;

  dew_state_type s_q;
  dew_state_type s_d;
  logic wr_fire;
  logic ctrl_vis;
  logic [7:0] v;
  logic [3:0] lo;

  ////////////////////////////////////////////////////////////////////////////
  // control register hides unless a pointer selects its sector
  assign ctrl_vis = (s_q.ptr1h == SECTOR_CTRL) || (s_q.ptr2h == SECTOR_CTRL);
  assign wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign v = s_q.w_data;
  assign lo = s_q.addr_lo[LOW_W-1:0];

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.abort_p = 1'b0;

    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_lane = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // register writes; any completed write closes the start window
    if (wr_fire) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      s_d.arm = 1'b0;
      unique case (s_q.aw_addr)
        OFS_CTRL: begin
          // settings are frozen while a cycle runs, so a half-done write stays coherent
          if (s_q.w_lane && ctrl_vis && !s_q.busy) begin
            s_d.mode = v[CTRL_MODE_BIT];
            s_d.write_enable_flag = v[CTRL_WRITE_ENABLE_FLAG_BIT];
            // only the write that raises the enable opens the window
            s_d.arm = v[CTRL_WRITE_ENABLE_FLAG_BIT] && !s_q.write_enable_flag && !v[CTRL_WR_BIT];
            if (v[CTRL_WR_BIT] && v[CTRL_WRITE_ENABLE_FLAG_BIT] && s_q.write_enable_flag && s_q.arm) begin
              s_d.wr = 1'b1;
              s_d.busy = 1'b1;
              s_d.start = 1'b1;
              s_d.page = v[CTRL_MODE_BIT];
              s_d.preerase = !v[CTRL_MODE_BIT];
              s_d.naddr = {s_q.addr_hi, s_q.addr_lo};
              if (v[CTRL_MODE_BIT]) begin
                s_d.ndata = s_q.pbuf;
                s_d.nmask = s_q.pmask;
              end else begin
                s_d.ndata = '0;
                s_d.nmask = '0;
                s_d.ndata[lo] = s_q.data;
                s_d.nmask[lo] = 1'b1;
              end
            end
            if (s_q.write_enable_flag && !v[CTRL_WRITE_ENABLE_FLAG_BIT]) begin
              s_d.pbuf = '0;
              s_d.pmask = '0;
              s_d.sat = 1'b0;
            end
          end
        end
        OFS_ADDR_LO: begin
          if (s_q.w_lane && !s_q.busy) begin
            s_d.addr_lo = v;
            s_d.sat = 1'b0;
          end
        end
        OFS_ADDR_HI: if (s_q.w_lane && !s_q.busy) s_d.addr_hi = v[ADDR_HI_W-1:0];
        OFS_DATA: begin
          // ignored outright during a cycle: data in flight stays untouched
          if (s_q.w_lane && !s_q.busy) begin
            s_d.data = v;
            if (s_q.mode && !s_q.sat) begin
              s_d.pbuf[lo] = v;
              s_d.pmask[lo] = 1'b1;
              // only the low nibble moves; the page bits are never carried into
              if (lo == LOW_MAX) begin
                s_d.sat = 1'b1;
              end else begin
                s_d.addr_lo[LOW_W-1:0] = lo + 4'h1;
              end
            end
          end
        end
        OFS_IRQ_FLAG: begin
          if (s_q.w_lane) begin
            s_d.nvm_flag = v[FLAG_NVM_BIT];
            s_d.mf_flag = v[FLAG_MF_BIT];
          end
        end
        OFS_IRQ_EN: begin
          if (s_q.w_lane) begin
            s_d.en_nvm = v[EN_NVM_BIT];
            s_d.en_mf = v[EN_MF_BIT];
            s_d.gie = v[EN_GLOBAL_BIT];
          end
        end
        OFS_PTR1_HI: if (s_q.w_lane) s_d.ptr1h = v;
        OFS_PTR2_HI: if (s_q.w_lane) s_d.ptr2h = v;
        OFS_STATUS: if (s_q.w_lane) s_d.fault = s_q.fault && v[STAT_FAULT_BIT];
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // read channel: answer one cycle after the address is taken
    if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
    if (s_q.arready && s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 8'h00;
      unique case (s_axi_araddr)
        OFS_CTRL: begin
          if (ctrl_vis) begin
            s_d.rdata[CTRL_MODE_BIT] = s_q.mode;
            s_d.rdata[CTRL_WRITE_ENABLE_FLAG_BIT] = s_q.write_enable_flag;
            s_d.rdata[CTRL_WR_BIT] = s_q.wr;
          end
        end
        OFS_ADDR_LO: s_d.rdata = s_q.addr_lo;
        OFS_ADDR_HI: s_d.rdata[ADDR_HI_W-1:0] = s_q.addr_hi;
        OFS_DATA: s_d.rdata = s_q.data;
        OFS_IRQ_FLAG: begin
          s_d.rdata[FLAG_NVM_BIT] = s_q.nvm_flag;
          s_d.rdata[FLAG_MF_BIT] = s_q.mf_flag;
        end
        OFS_IRQ_EN: begin
          s_d.rdata[EN_NVM_BIT] = s_q.en_nvm;
          s_d.rdata[EN_MF_BIT] = s_q.en_mf;
          s_d.rdata[EN_GLOBAL_BIT] = s_q.gie;
        end
        OFS_PTR1_HI: s_d.rdata = s_q.ptr1h;
        OFS_PTR2_HI: s_d.rdata = s_q.ptr2h;
        OFS_STATUS: begin
          s_d.rdata[STAT_BUSY_BIT] = s_q.busy;
          s_d.rdata[STAT_SAT_BIT] = s_q.sat;
          s_d.rdata[STAT_FAULT_BIT] = s_q.fault;
        end
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt service comes before cycle end so a new request survives it
    if (irq_service) begin
      s_d.mf_flag = 1'b0;
      s_d.gie = 1'b0;
    end

    if (s_q.busy && nvm_done) begin
      s_d.busy = 1'b0;
      s_d.wr = 1'b0;
      s_d.write_enable_flag = 1'b0;
      s_d.arm = 1'b0;
      s_d.pbuf = '0;
      s_d.pmask = '0;
      s_d.sat = 1'b0;
      s_d.nvm_flag = 1'b1;
      s_d.mf_flag = 1'b1;
    end else if (s_q.busy && sleep_req) begin
      // a low-power entry kills the cycle; nothing signals completion
      s_d.busy = 1'b0;
      s_d.wr = 1'b0;
      s_d.abort_p = 1'b1;
      s_d.fault = 1'b1;
    end

    s_d.vector = s_d.gie && s_d.en_nvm && s_d.en_mf && s_d.mf_flag
                 && !stack_full && !irq_service;
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = {24'h000000, s_q.rdata};
  assign nvm_start = s_q.start;
  assign nvm_preerase = s_q.preerase;
  assign nvm_page = s_q.page;
  assign nvm_addr = s_q.naddr;
  assign nvm_data = s_q.ndata;
  assign nvm_mask = s_q.nmask;
  assign nvm_abort = s_q.abort_p;
  assign irq_vector = s_q.vector;

  ////////////////////////////////////////////////////////////////////////////
  default clocking dew_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_start_after_arm: assert property (
    s_q.start |-> $past(s_q.arm) && $past(s_q.write_enable_flag) && s_q.busy)
    else $error("start without enable in the previous write");
  a_busy_needs_enable: assert property (
    $rose(s_q.busy) |-> $past(s_q.write_enable_flag) && s_q.wr && s_q.start)
    else $error("cycle began while enable clear");
  a_done_clears_bits: assert property (
    s_q.busy && nvm_done |=> !s_q.wr && !s_q.busy && !s_q.write_enable_flag)
    else $error("cycle end did not clear start and enable");
  a_byte_preerase: assert property (
    s_q.start |-> (s_q.preerase == !s_q.page) && (s_q.page || $onehot(s_q.nmask)))
    else $error("byte write lacks pre-erase or single lane");
  a_mode_selects: assert property (
    s_q.start |-> s_q.page == s_q.mode)
    else $error("page flag does not follow mode");
  a_buffer_clear: assert property (
    $fell(s_q.write_enable_flag) |-> s_q.pmask == '0 && !s_q.sat)
    else $error("buffer kept after enable fell");
  a_page_fixed: assert property (
    !(wr_fire && (s_q.aw_addr == OFS_ADDR_LO || s_q.aw_addr == OFS_ADDR_HI))
    |=> $stable(s_q.addr_hi) && $stable(s_q.addr_lo[7:4]))
    else $error("page bits moved without software");
  a_low_increment: assert property (
    wr_fire && s_q.aw_addr == OFS_DATA && s_q.w_lane && s_q.mode && !s_q.busy
    && !s_q.sat && lo != LOW_MAX && !nvm_done
    |=> s_q.addr_lo[3:0] == $past(lo) + 4'h1 && s_q.pmask[$past(lo)])
    else $error("page data write did not load and advance");
  a_low_saturates: assert property (
    lo == LOW_MAX && !(wr_fire && s_q.aw_addr == OFS_ADDR_LO) |=> lo == LOW_MAX)
    else $error("low nibble rolled over");
  a_flags_on_end: assert property (
    s_q.busy && nvm_done |=> s_q.nvm_flag && s_q.mf_flag)
    else $error("cycle end left flags clear");
  a_vector_gated: assert property (
    s_q.vector |-> s_q.gie && s_q.en_nvm && s_q.en_mf && s_q.mf_flag && !$past(stack_full))
    else $error("vector raised without all enables");
  a_service_clears: assert property (
    irq_service |=> !s_q.gie && !s_q.vector)
    else $error("service left global enable set");
  a_busy_data_frozen: assert property (
    s_q.busy && !nvm_done && !sleep_req |=> $stable(s_q.pbuf) && $stable(s_q.data))
    else $error("data changed during cycle");

  c_byte_write: cover property (s_q.start && !s_q.page);
  c_page_write: cover property (s_q.start && s_q.page && s_q.nmask == 16'hFFFF);
  c_vector: cover property (s_q.vector);
  c_abort: cover property (s_q.abort_p);

endmodule

`default_nettype wire

// file: testbench/test_data_eeprom_write_control.sv
`timescale 1ns/1ns
`default_nettype none

module test_data_eeprom_write_control;
  import dew_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_AW-1:0] awaddr = 8'h00;
  logic [AXI_AW-1:0] araddr = 8'h00;
  logic [AXI_DW-1:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [AXI_DW-1:0] rdata;
  logic nvm_start, nvm_preerase, nvm_page, nvm_abort, irq_vector;
  logic [NVM_AW-1:0] nvm_addr;
  logic [PAGE_BYTES*8-1:0] nvm_data;
  logic [PAGE_BYTES-1:0] nvm_mask;
  logic nvm_done = 1'b0, stack_full = 1'b1, irq_service = 1'b0, sleep_req = 1'b0;
  int bad_count = 0;
  int compares = 0;
  int starts = 0;
  int aborts = 0;
  logic [NVM_AW-1:0] cap_addr;
  logic [PAGE_BYTES*8-1:0] cap_data;
  logic [PAGE_BYTES-1:0] cap_mask;
  logic cap_page, cap_pre;

  dew_write_ctrl uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .nvm_start(nvm_start), .nvm_preerase(nvm_preerase), .nvm_page(nvm_page),
    .nvm_addr(nvm_addr), .nvm_data(nvm_data), .nvm_mask(nvm_mask), .nvm_abort(nvm_abort),
    .nvm_done(nvm_done), .stack_full(stack_full), .irq_service(irq_service),
    .sleep_req(sleep_req), .irq_vector(irq_vector)
  );

  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  // array-side monitor: the start pulse stands one cycle, so catch it here
  always @(posedge aclk) begin
    if (nvm_start === 1'b1) begin
      starts++;
      cap_addr = nvm_addr;
      cap_data = nvm_data;
      cap_mask = nvm_mask;
      cap_page = nvm_page;
      cap_pre = nvm_preerase;
    end
    if (nvm_abort === 1'b1) begin
      aborts++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic timed_out(input int n);
    if (n >= 200) begin
      bad_count++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    timed_out(n);
    check("write response", 32'(bresp), 32'(er));
    bready <= 1'b0;
    // one more edge so the start monitor has settled before callers look
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp,
                        input logic [1:0] er, input string nm);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    timed_out(n);
    check("read response", 32'(rresp), 32'(er));
    check(nm, rdata & msk, exp);
    rready <= 1'b0;
  endtask

  task automatic pulse_done();
    @(posedge aclk);
    nvm_done <= 1'b1;
    @(posedge aclk);
    nvm_done <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(OFS_PTR1_HI, 32'hFF, 32'h0, RESP_OKAY, "pointer high reset");
    wr(OFS_CTRL, 32'h08, RESP_OKAY);
    wr(OFS_PTR1_HI, 32'h01, RESP_OKAY);
    rd_chk(OFS_CTRL, 32'h1C, 32'h0, RESP_OKAY, "control while hidden");
    wr(8'h40, 32'h0, RESP_SLVERR);
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0, RESP_SLVERR, "unmapped read");
    wr(OFS_CTRL, 32'h04, RESP_OKAY);
    rd_chk(OFS_CTRL, 32'h1C, 32'h0, RESP_OKAY, "start without enable");
    check("starts none", 32'(starts), 32'h0);
    // byte write: global enable stays off until the start is in, stack full first
    wr(OFS_IRQ_EN, 32'h03, RESP_OKAY);
    wr(OFS_ADDR_HI, 32'h03, RESP_OKAY);
    wr(OFS_ADDR_LO, 32'h5A, RESP_OKAY);
    wr(OFS_DATA, 32'hC3, RESP_OKAY);
    wr(OFS_CTRL, 32'h08, RESP_OKAY);
    wr(OFS_CTRL, 32'h0C, RESP_OKAY);
    wr(OFS_IRQ_EN, 32'h07, RESP_OKAY);
    check("byte start", 32'(starts), 32'h1);
    check("byte page flag", 32'(cap_page), 32'h0);
    check("byte pre-erase", 32'(cap_pre), 32'h1);
    check("byte address", 32'(cap_addr), 32'h35A);
    check("byte mask", 32'(cap_mask), 32'h0400);
    check("byte lane", 32'(cap_data[8*10 +: 8]), 32'hC3);
    rd_chk(OFS_CTRL, 32'h04, 32'h04, RESP_OKAY, "start bit busy");
    wr(OFS_DATA, 32'h77, RESP_OKAY);
    check("lane during cycle", 32'(nvm_data[8*10 +: 8]), 32'hC3);
    rd_chk(OFS_DATA, 32'hFF, 32'hC3, RESP_OKAY, "data during cycle");
    pulse_done();
    rd_chk(OFS_CTRL, 32'h1C, 32'h0, RESP_OKAY, "control after byte");
    rd_chk(OFS_IRQ_FLAG, 32'h03, 32'h03, RESP_OKAY, "flags after byte");
    check("vector stack full", 32'(irq_vector), 32'h0);
    stack_full <= 1'b0;
    repeat (3) @(posedge aclk);
    check("vector raised", 32'(irq_vector), 32'h1);
    irq_service <= 1'b1;
    @(posedge aclk);
    irq_service <= 1'b0;
    repeat (2) @(posedge aclk);
    check("vector after service", 32'(irq_vector), 32'h0);
    rd_chk(OFS_IRQ_FLAG, 32'h03, 32'h01, RESP_OKAY, "flags after service");
    rd_chk(OFS_IRQ_EN, 32'h07, 32'h03, RESP_OKAY, "enables after service");
    // a write between enable and start breaks the sequence
    wr(OFS_CTRL, 32'h08, RESP_OKAY);
    wr(OFS_DATA, 32'h11, RESP_OKAY);
    wr(OFS_CTRL, 32'h0C, RESP_OKAY);
    check("broken sequence", 32'(starts), 32'h1);
    // a write with the low byte lane off changes nothing
    wstrb <= 4'h0;
    wr(OFS_DATA, 32'h99, RESP_OKAY);
    wstrb <= 4'hF;
    rd_chk(OFS_DATA, 32'hFF, 32'h11, RESP_OKAY, "data without lane");
    wr(OFS_CTRL, 32'h00, RESP_OKAY);
    // page write from slot D into a page taken as erased: the third byte finds F, the fourth is not buffered
    wr(OFS_CTRL, 32'h10, RESP_OKAY);
    wr(OFS_ADDR_HI, 32'h01, RESP_OKAY);
    wr(OFS_ADDR_LO, 32'h2D, RESP_OKAY);
    for (int i = 0; i < 4; i++) wr(OFS_DATA, 32'hA0 + 32'(i), RESP_OKAY);
    rd_chk(OFS_ADDR_LO, 32'hFF, 32'h2F, RESP_OKAY, "saturated low address");
    rd_chk(OFS_STATUS, 32'h02, 32'h02, RESP_OKAY, "saturated status");
    wr(OFS_CTRL, 32'h18, RESP_OKAY);
    wr(OFS_CTRL, 32'h1C, RESP_OKAY);
    check("page start", 32'(starts), 32'h2);
    check("page flag", 32'(cap_page), 32'h1);
    check("page pre-erase", 32'(cap_pre), 32'h0);
    check("page number", 32'(cap_addr[9:4]), 32'h12);
    check("page mask", 32'(cap_mask), 32'hE000);
    for (int i = 0; i < 3; i++) begin
      check("page lane", 32'(cap_data[8*(13+i) +: 8]), 32'hA0 + 32'(i));
    end
    pulse_done();
    rd_chk(OFS_CTRL, 32'h1C, 32'h10, RESP_OKAY, "control after page");
    // enable rising keeps the buffer, falling empties it
    wr(OFS_ADDR_LO, 32'h20, RESP_OKAY);
    wr(OFS_DATA, 32'h55, RESP_OKAY);
    wr(OFS_CTRL, 32'h18, RESP_OKAY);
    wr(OFS_CTRL, 32'h10, RESP_OKAY);
    wr(OFS_DATA, 32'h66, RESP_OKAY);
    wr(OFS_CTRL, 32'h18, RESP_OKAY);
    wr(OFS_CTRL, 32'h1C, RESP_OKAY);
    check("clear start", 32'(starts), 32'h3);
    check("mask after clear", 32'(cap_mask), 32'h0002);
    check("lane after clear", 32'(cap_data[15:8]), 32'h66);
    // sleep in mid-cycle kills it without raising the flags
    wr(OFS_IRQ_FLAG, 32'h00, RESP_OKAY);
    @(posedge aclk);
    sleep_req <= 1'b1;
    repeat (2) @(posedge aclk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge aclk);
    check("abort pulse", 32'(aborts), 32'h1);
    rd_chk(OFS_CTRL, 32'h04, 32'h0, RESP_OKAY, "start bit after abort");
    rd_chk(OFS_STATUS, 32'h04, 32'h04, RESP_OKAY, "fault status");
    rd_chk(OFS_IRQ_FLAG, 32'h03, 32'h0, RESP_OKAY, "no flags on abort");
    wr(OFS_STATUS, 32'h00, RESP_OKAY);
    rd_chk(OFS_STATUS, 32'h04, 32'h00, RESP_OKAY, "fault cleared");
    // the second pointer alone opens the control register too
    wr(OFS_PTR1_HI, 32'h00, RESP_OKAY);
    rd_chk(OFS_CTRL, 32'h1C, 32'h0, RESP_OKAY, "control hidden again");
    wr(OFS_PTR2_HI, 32'h01, RESP_OKAY);
    rd_chk(OFS_CTRL, 32'h1C, 32'h18, RESP_OKAY, "control via second pointer");
    test_done();
  end
endmodule

`default_nettype wire
